//--- src/dtc_top.sv
// Purpose: Two 16-bit timer/counters with APB register access
// Assumes: APB slave, zero wait states, pclk at 25 MHz
// Notes: Overflow flags are the interrupt request outputs
`timescale 1ns/10ps
`default_nettype none
`include "dtc_params.svh"
module dtc_top
  import dtc_pkg::*;
#(
  parameter int ADDR_W = 12
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic count_input_0,
  input wire logic count_input_1,
  input wire logic gate_input_0,
  input wire logic gate_input_1,
  input wire logic intr_ack_0,
  input wire logic intr_ack_1,
  output logic overflow_flag_0,
  output logic overflow_flag_1
);
  logic [`DTC_MC_W-1:0] mc_count;
  logic tick;
  logic [7:0] timer_mode_control;
  logic run_control_0;
  logic run_control_1;
  logic [7:0] low_byte_0;
  logic [7:0] high_byte_0;
  logic [7:0] low_byte_1;
  logic [7:0] high_byte_1;
  logic [1:0] fall;
  logic [1:0] gate_level;
  logic [1:0] pin_count;
  logic [1:0] pin_gate;

  // Step one timer: returns {ovf_high, ovf_low, high, low}
  function automatic logic [17:0] dtc_step(input dtc_mode_t mode, input logic split,
                                           input logic [7:0] lo, input logic [7:0] hi,
                                           input logic inc_lo, input logic inc_hi);
    logic [13:0] s13;
    logic [16:0] s16;
    logic [8:0] s8l;
    logic [8:0] s8h;
    logic [17:0] r;
    s13 = {1'b0, hi, lo[4:0]} + 14'h0001;
    s16 = {1'b0, hi, lo} + 17'h00001;
    s8l = {1'b0, lo} + 9'h001;
    s8h = {1'b0, hi} + 9'h001;
    r = {2'b00, hi, lo};
    case (mode)
      dtc_mode13: begin
        if (inc_lo) begin
          r = {1'b0, s13[13], s13[12:5], lo[7:5], s13[4:0]};
        end
      end
      dtc_mode16: begin
        if (inc_lo) begin
          r = {1'b0, s16};
        end
      end
      dtc_mode8_reload: begin
        if (inc_lo) begin
          r = {1'b0, s8l[8], hi, s8l[8] ? hi : s8l[7:0]};
        end
      end
      default: begin
        if (split) begin
          r = {inc_hi & s8h[8], inc_lo & s8l[8],
               inc_hi ? s8h[7:0] : hi, inc_lo ? s8l[7:0] : lo};
        end
      end
    endcase
    return r;
  endfunction

  // Machine-cycle prescaler
  assign tick = (mc_count == `DTC_MC_W'(`DTC_MC_CLOCKS - 1));
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mc_count <= '0;
    end else begin
      mc_count <= tick ? '0 : mc_count + `DTC_MC_W'(1);
    end
  end

  assign pin_count = {count_input_1, count_input_0};
  assign pin_gate = {gate_input_1, gate_input_0};

  for (genvar i = 0; i < 2; i++) begin : g_pin
    dtc_input_sampler u_sampler (
      .pclk(pclk),
      .presetn(presetn),
      .tick(tick),
      .count_pin(pin_count[i]),
      .gate_pin(pin_gate[i]),
      .fall(fall[i]),
      .gate_level(gate_level[i])
    );
  end

  // Mode fields and count enables
  dtc_mode_t mode0;
  dtc_mode_t mode1;
  logic enable0;
  logic enable1;
  logic inc0;
  logic inc1;
  logic inc0_high;
  logic split0;
  assign mode0 = dtc_mode_t'(timer_mode_control[`DTC_MOD_MODE0_HI:`DTC_MOD_MODE0_LO]);
  assign mode1 = dtc_mode_t'(timer_mode_control[`DTC_MOD_MODE1_HI:`DTC_MOD_MODE1_LO]);
  assign split0 = (mode0 == dtc_mode_split);
  assign enable0 = run_control_0 & (~timer_mode_control[`DTC_MOD_GATE0] | gate_level[0]);
  assign enable1 = run_control_1 & (~timer_mode_control[`DTC_MOD_GATE1] | gate_level[1]);
  assign inc0 = enable0 & (timer_mode_control[`DTC_MOD_CT0] ? fall[0] : tick);
  assign inc1 = enable1 & (timer_mode_control[`DTC_MOD_CT1] ? fall[1] : tick);
  assign inc0_high = run_control_1 & tick;

  logic [17:0] step0;
  logic [17:0] step1;
  // Timer 1 split step never taken: mode 11 holds it
  assign step0 = dtc_step(mode0, 1'b1, low_byte_0, high_byte_0, inc0, inc0_high);
  assign step1 = dtc_step(mode1, 1'b0, low_byte_1, high_byte_1, inc1, 1'b0);

  // APB decode
  logic [7:0] idx;
  logic addr_ok;
  logic wr_en;
  logic wr_rf;
  logic wr_mode;
  logic wr_low0;
  logic wr_low1;
  logic wr_high0;
  logic wr_high1;
  assign idx = paddr[9:2];
  assign addr_ok = ~|paddr[ADDR_W-1:10] & ~|paddr[1:0];
  assign wr_en = psel & penable & pwrite & pstrb[0] & addr_ok;
  assign wr_rf = wr_en & (idx == `DTC_IDX_RUN_FLAG);
  assign wr_mode = wr_en & (idx == `DTC_IDX_MODE);
  assign wr_low0 = wr_en & (idx == `DTC_IDX_LOW0);
  assign wr_low1 = wr_en & (idx == `DTC_IDX_LOW1);
  assign wr_high0 = wr_en & (idx == `DTC_IDX_HIGH0);
  assign wr_high1 = wr_en & (idx == `DTC_IDX_HIGH1);

  // Overflow flags: set wins over any clear
  logic set0;
  logic set1;
  logic clr0;
  logic clr1;
  logic next_ovf0;
  logic next_ovf1;
  assign set0 = step0[16];
  assign set1 = (split0 ? step0[17] : step1[16]);
  assign clr0 = intr_ack_0 | (wr_rf & ~pwdata[`DTC_RF_OVF0]);
  assign clr1 = intr_ack_1 | (wr_rf & ~pwdata[`DTC_RF_OVF1]);
  assign next_ovf0 = set0 | (overflow_flag_0 & ~clr0);
  assign next_ovf1 = set1 | (overflow_flag_1 & ~clr1);

  // Software writes take priority over a count in the same cycle
  logic [7:0] next_low0;
  logic [7:0] next_high0;
  logic [7:0] next_low1;
  logic [7:0] next_high1;
  assign next_low0 = wr_low0 ? pwdata[7:0] : step0[7:0];
  assign next_high0 = wr_high0 ? pwdata[7:0] : step0[15:8];
  assign next_low1 = wr_low1 ? pwdata[7:0] : step1[7:0];
  assign next_high1 = wr_high1 ? pwdata[7:0] : step1[15:8];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      low_byte_0 <= `DTC_COUNT_RESET;
      high_byte_0 <= `DTC_COUNT_RESET;
      low_byte_1 <= `DTC_COUNT_RESET;
      high_byte_1 <= `DTC_COUNT_RESET;
    end else begin
      low_byte_0 <= next_low0;
      high_byte_0 <= next_high0;
      low_byte_1 <= next_low1;
      high_byte_1 <= next_high1;
    end
  end

  // Run bits only gate counting; they never touch the counts
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      timer_mode_control <= `DTC_MODE_RESET;
      run_control_0 <= 1'b0;
      run_control_1 <= 1'b0;
      overflow_flag_0 <= 1'b0;
      overflow_flag_1 <= 1'b0;
    end else begin
      if (wr_mode) begin
        timer_mode_control <= pwdata[7:0];
      end
      if (wr_rf) begin
        run_control_0 <= pwdata[`DTC_RF_RUN0];
        run_control_1 <= pwdata[`DTC_RF_RUN1];
      end
      overflow_flag_0 <= next_ovf0;
      overflow_flag_1 <= next_ovf1;
    end
  end

  // Read mux; answer captured in the setup cycle
  logic [7:0] rd_byte;
  logic rd_hit;
  always_comb begin
    rd_byte = 8'h00;
    rd_hit = addr_ok;
    if (idx == `DTC_IDX_RUN_FLAG) begin
      rd_byte = 8'h00;
      rd_byte[`DTC_RF_OVF1] = overflow_flag_1;
      rd_byte[`DTC_RF_RUN1] = run_control_1;
      rd_byte[`DTC_RF_OVF0] = overflow_flag_0;
      rd_byte[`DTC_RF_RUN0] = run_control_0;
    end else if (idx == `DTC_IDX_MODE) begin
      rd_byte = timer_mode_control;
    end else if (idx == `DTC_IDX_LOW0) begin
      rd_byte = low_byte_0;
    end else if (idx == `DTC_IDX_LOW1) begin
      rd_byte = low_byte_1;
    end else if (idx == `DTC_IDX_HIGH0) begin
      rd_byte = high_byte_0;
    end else if (idx == `DTC_IDX_HIGH1) begin
      rd_byte = high_byte_1;
    end else begin
      rd_hit = 1'b0;
    end
  end

  assign pready = 1'b1;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h0000_0000;
      pslverr <= 1'b0;
    end else if (psel & ~penable) begin
      prdata <= (rd_hit & ~pwrite) ? {24'h00_0000, rd_byte} : 32'h0000_0000;
      pslverr <= ~rd_hit;
    end
  end

  // Checks
  sequence s_tick_pair;
    tick ##12 tick;
  endsequence

  a_tick_spacing:
    assert property (@(posedge pclk) disable iff (!presetn) tick |-> s_tick_pair)
    else $error("machine cycle tick not every 12 clocks");

  a_tick_gap:
    assert property (@(posedge pclk) disable iff (!presetn) tick |=> (!tick)[*8])
    else $error("machine cycle tick too early");

  a_run_stop_hold:
    assert property (@(posedge pclk) disable iff (!presetn)
      (!run_control_0 && !split0 && !wr_en) |=> ({high_byte_0, low_byte_0} ==
      $past({high_byte_0, low_byte_0})))
    else $error("stopped timer 0 changed");

  a_gate_blocks:
    assert property (@(posedge pclk) disable iff (!presetn)
      (timer_mode_control[`DTC_MOD_GATE0] && !gate_level[0] && !split0 && !wr_en) |=>
      ({high_byte_0, low_byte_0} == $past({high_byte_0, low_byte_0})))
    else $error("gated timer 0 counted with gate low");

  a_counter_edge:
    assert property (@(posedge pclk) disable iff (!presetn)
      (mode1 == dtc_mode16 && timer_mode_control[`DTC_MOD_CT1] && enable1 && fall[1] &&
      !wr_en) |=> ({high_byte_1, low_byte_1} == $past({high_byte_1, low_byte_1}) + 16'h0001))
    else $error("counter did not step on input fall");

  a_mode3_hold:
    assert property (@(posedge pclk) disable iff (!presetn)
      (mode1 == dtc_mode_split && !wr_en) |=> $stable({high_byte_1, low_byte_1}))
    else $error("timer 1 counted in mode 11");

  a_reload_flag:
    assert property (@(posedge pclk) disable iff (!presetn)
      (mode1 == dtc_mode8_reload && !split0 && inc1 && low_byte_1 == 8'hff && !wr_en) |=>
      (low_byte_1 == $past(high_byte_1) && overflow_flag_1 && $stable(high_byte_1)))
    else $error("auto-reload or flag missing");

  a_split_high:
    assert property (@(posedge pclk) disable iff (!presetn)
      (split0 && tick && run_control_1 && !wr_en) |=>
      (high_byte_0 == $past(high_byte_0) + 8'h01))
    else $error("split high byte did not count");

  a_mode0_prescale:
    assert property (@(posedge pclk) disable iff (!presetn)
      (mode0 == dtc_mode13 && inc0 && low_byte_0[4:0] == 5'h1f && !wr_en) |=>
      (high_byte_0 == $past(high_byte_0) + 8'h01 && low_byte_0[4:0] == 5'h00 &&
      low_byte_0[7:5] == $past(low_byte_0[7:5])))
    else $error("13-bit carry wrong");

  a_flag_set_wins:
    assert property (@(posedge pclk) disable iff (!presetn)
      (set1 && (intr_ack_1 || wr_rf)) |=> overflow_flag_1)
    else $error("overflow lost against clear");
endmodule
`default_nettype wire

//--- common/dtc_params.svh
// Purpose: Offsets, field positions, reset values and counts of the dual timer/counter
// Assumes: Register indices become byte addresses by multiplying by four
// Notes: Definitions only
`ifndef DTC_PARAMS_SVH
`define DTC_PARAMS_SVH

// Register indices (byte address = index * 4)
`define DTC_IDX_RUN_FLAG 8'h88
`define DTC_IDX_MODE 8'h89
`define DTC_IDX_LOW0 8'h8a
`define DTC_IDX_LOW1 8'h8b
`define DTC_IDX_HIGH0 8'h8c
`define DTC_IDX_HIGH1 8'h8d

// Reset values
`define DTC_MODE_RESET 8'h00
`define DTC_COUNT_RESET 8'h00

// timer_mode_control fields
`define DTC_MOD_GATE1 7
`define DTC_MOD_CT1 6
`define DTC_MOD_MODE1_HI 5
`define DTC_MOD_MODE1_LO 4
`define DTC_MOD_GATE0 3
`define DTC_MOD_CT0 2
`define DTC_MOD_MODE0_HI 1
`define DTC_MOD_MODE0_LO 0

// timer_run_flag_control fields
`define DTC_RF_OVF1 7
`define DTC_RF_RUN1 6
`define DTC_RF_OVF0 5
`define DTC_RF_RUN0 4

// Clock periods per machine cycle
`define DTC_MC_CLOCKS 12
// Width of the machine-cycle prescaler
`define DTC_MC_W 4

`endif

//--- common/dtc_pkg.sv
// Purpose: Types shared by the dual timer/counter
// Assumes: Mode field encodes 00, 01, 10, 11 in enum order
// Notes: Constants live in dtc_params.svh
`default_nettype none
package dtc_pkg;
  typedef enum logic [1:0] {
    dtc_mode13,
    dtc_mode16,
    dtc_mode8_reload,
    dtc_mode_split
  } dtc_mode_t;
endpackage
`default_nettype wire

//--- src/dtc_input_sampler.sv
// Purpose: Synchronise one count pin and one gate pin, detect count falls
// Assumes: tick is a one-cycle pulse once per machine cycle
// Notes: fall pulses one cycle after the tick that sees the low sample
`timescale 1ns/10ps
`default_nettype none
module dtc_input_sampler (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic tick,
  input wire logic count_pin,
  input wire logic gate_pin,
  output logic fall,
  output logic gate_level
);
  logic count_meta;
  logic count_sync;
  logic gate_meta;
  logic last_sample;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      count_meta <= 1'b0;
      count_sync <= 1'b0;
      gate_meta <= 1'b0;
      gate_level <= 1'b0;
    end else begin
      count_meta <= count_pin;
      count_sync <= count_meta;
      gate_meta <= gate_pin;
      gate_level <= gate_meta;
    end
  end

  // One sample per machine cycle; high then low is one count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      last_sample <= 1'b0;
      fall <= 1'b0;
    end else begin
      if (tick) begin
        last_sample <= count_sync;
      end
      fall <= tick & last_sample & ~count_sync;
    end
  end
endmodule
`default_nettype wire

//--- sim/dtc_pin_model.sv
// Purpose: Far-side model of the count and gate pins
// Assumes: Levels change just after a rising pclk edge
// Notes: Each level held 13 clocks, longer than one machine cycle
`timescale 1ns/10ps
`default_nettype none
module dtc_pin_model (
  input wire logic pclk,
  output logic count_0,
  output logic count_1,
  output logic gate_0,
  output logic gate_1
);
  localparam int HOLD = 13;
  initial begin
    count_0 = 1'b1;
    count_1 = 1'b1;
    gate_0 = 1'b0;
    gate_1 = 1'b0;
  end
  task automatic falls(input int pin, input int n);
    for (int i = 0; i < n; i++) begin
      repeat (HOLD) @(posedge pclk);
      if (pin == 0) count_0 <= 1'b0;
      else count_1 <= 1'b0;
      repeat (HOLD) @(posedge pclk);
      if (pin == 0) count_0 <= 1'b1;
      else count_1 <= 1'b1;
    end
  endtask
  task automatic set_gate(input int pin, input logic v);
    @(posedge pclk);
    if (pin == 0) gate_0 <= v;
    else gate_1 <= v;
  endtask
endmodule
`default_nettype wire

//--- sim/tb_dual_timer_counter.sv
// Purpose: Self-checking bench for the dual timer/counter
// Assumes: Zero-wait APB slave, pins driven by dtc_pin_model
// Notes: Timed runs span whole machine cycles so tick phase cancels
`timescale 1ns/10ps
`default_nettype none
`include "dtc_params.svh"
module tb_dual_timer_counter;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdata;
  logic [3:0] pstrb;
  logic rerr, intr_ack_0, intr_ack_1, overflow_flag_0, overflow_flag_1;
  logic count_input_0, count_input_1, gate_input_0, gate_input_1;
  int error_cnt, cmp_count;

  dtc_top #(.ADDR_W(12)) dut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb,
    .prdata, .pready, .pslverr, .count_input_0, .count_input_1,
    .gate_input_0, .gate_input_1, .intr_ack_0, .intr_ack_1,
    .overflow_flag_0, .overflow_flag_1
  );
  dtc_pin_model pm (
    .pclk, .count_0(count_input_0), .count_1(count_input_1),
    .gate_0(gate_input_0), .gate_1(gate_input_1)
  );

  initial begin
    pclk = 1'b0;
    forever #20 pclk = ~pclk;
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", cmp_count, error_cnt);
    if (error_cnt == 0 && cmp_count > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string what);
    cmp_count++;
    if (seen !== exp) begin
      error_cnt++;
      $display("unexpected %s expected %h seen %h", what, exp, seen);
    end
  endtask

  // One APB transfer; register index becomes byte address
  task automatic xfer(input logic [7:0] idx, input logic wr, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdata = prdata;
    rerr = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] idx, input logic [7:0] exp, input string what);
    xfer(idx, 1'b0, 8'h00);
    chk(rdata, {24'h0, exp}, what);
    chk({31'h0, rerr}, 32'h0, "pslverr");
  endtask

  task automatic setc(input logic [7:0] l0, h0, l1, h1);
    xfer(`DTC_IDX_LOW0, 1'b1, l0);
    xfer(`DTC_IDX_HIGH0, 1'b1, h0);
    xfer(`DTC_IDX_LOW1, 1'b1, l1);
    xfer(`DTC_IDX_HIGH1, 1'b1, h1);
  endtask

  task automatic expc(input logic [7:0] l0, h0, l1, h1);
    rdchk(`DTC_IDX_LOW0, l0, "low_byte_0");
    rdchk(`DTC_IDX_HIGH0, h0, "high_byte_0");
    rdchk(`DTC_IDX_LOW1, l1, "low_byte_1");
    rdchk(`DTC_IDX_HIGH1, h1, "high_byte_1");
  endtask

  // Run for exactly k machine cycles between the two write edges
  task automatic run_mc(input logic [7:0] run, input int k, input logic f1, input logic f0);
    xfer(`DTC_IDX_RUN_FLAG, 1'b1, run);
    repeat (`DTC_MC_CLOCKS * k - 3) @(posedge pclk);
    chk({30'h0, overflow_flag_1, overflow_flag_0}, {30'h0, f1, f0}, "flags");
    xfer(`DTC_IDX_RUN_FLAG, 1'b1, 8'ha0);
    repeat (30) @(posedge pclk);
  endtask

  task automatic ack(input logic [1:0] which);
    @(posedge pclk);
    intr_ack_1 <= which[1];
    intr_ack_0 <= which[0];
    @(posedge pclk);
    intr_ack_1 <= 1'b0;
    intr_ack_0 <= 1'b0;
    @(posedge pclk);
  endtask

  initial begin
    error_cnt = 0;
    cmp_count = 0;
    presetn = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0;
    pstrb = 4'h1;
    intr_ack_0 = 1'b0;
    intr_ack_1 = 1'b0;
    repeat (16) @(posedge pclk);
    presetn <= 1'b1;
    rdchk(`DTC_IDX_MODE, `DTC_MODE_RESET, "mode reset");
    rdchk(`DTC_IDX_RUN_FLAG, 8'h00, "run flag reset");
    expc(8'h00, 8'h00, 8'h00, 8'h00);
    xfer(8'h00, 1'b0, 8'h00);
    chk(rdata, 32'h0, "unmapped data");
    chk({31'h0, rerr}, 32'h1, "unmapped error");
    chk({31'h0, pready}, 32'h1, "pready");
    // 13-bit timer 0 beside 8-bit reload timer 1
    xfer(`DTC_IDX_MODE, 1'b1, 8'h20);
    setc(8'hfe, 8'hff, 8'hfe, 8'h80);
    run_mc(8'h50, 3, 1'b1, 1'b1);
    expc(8'he1, 8'h00, 8'h81, 8'h80);
    rdchk(`DTC_IDX_RUN_FLAG, 8'ha0, "flags kept");
    ack(2'b01);
    chk({31'h0, overflow_flag_0}, 32'h0, "ack clear");
    xfer(`DTC_IDX_RUN_FLAG, 1'b1, 8'h20);
    rdchk(`DTC_IDX_RUN_FLAG, 8'h00, "soft clear");
    // 16-bit timer 0, timer 1 left stopped
    xfer(`DTC_IDX_MODE, 1'b1, 8'h11);
    setc(8'hfe, 8'hff, 8'h33, 8'h44);
    run_mc(8'h10, 3, 1'b0, 1'b1);
    expc(8'h01, 8'h00, 8'h33, 8'h44);
    ack(2'b01);
    // Split timer 0, timer 1 held
    xfer(`DTC_IDX_MODE, 1'b1, 8'h33);
    setc(8'hfe, 8'hfe, 8'h55, 8'h66);
    run_mc(8'h50, 3, 1'b1, 1'b1);
    expc(8'h01, 8'h01, 8'h55, 8'h66);
    ack(2'b10);
    xfer(`DTC_IDX_RUN_FLAG, 1'b1, 8'h00);
    // Clear lands at the write edge; look one edge later
    @(posedge pclk);
    chk({30'h0, overflow_flag_1, overflow_flag_0}, 32'h0, "flags off");
    // Counters: timer 0 gated, timer 1 free
    xfer(`DTC_IDX_MODE, 1'b1, 8'h5d);
    setc(8'h00, 8'h00, 8'h00, 8'h00);
    xfer(`DTC_IDX_RUN_FLAG, 1'b1, 8'h50);
    pm.falls(0, 3);
    pm.falls(1, 3);
    pm.set_gate(0, 1'b1);
    pm.falls(0, 2);
    repeat (40) @(posedge pclk);
    xfer(`DTC_IDX_RUN_FLAG, 1'b1, 8'h00);
    expc(8'h02, 8'h00, 8'h03, 8'h00);
    conclude();
  end

  initial begin
    repeat (20000) @(posedge pclk);
    error_cnt++;
    conclude();
  end
endmodule
`default_nettype wire
